// file: tmr_timer.sv
// 8-bit timer/counter with one compare output and pwm
// assumes one i/o clock, synchronous reset, byte register port with read data one cycle later
`timescale 1ns/1ps
`default_nettype none
module tmr_timer (
    input wire logic ref_clk,               // i/o clock, 25 mhz
    input wire logic sys_rst,               // synchronous reset, active high
    input wire tmr_pkg::tmr_bus_req_t bus,  // register port request
    output logic [7:0] rdata,               // read data, cycle after read strobe
    input wire logic global_irq_en,         // processor global interrupt enable
    input wire logic cmp_irq_ack,           // compare vector executing
    input wire logic ovf_irq_ack,           // overflow vector executing
    input wire logic port_data,             // normal port data for the pin
    input wire logic port_dir_out,          // direction bit, 1 = output
    output logic pin_out,                   // pin output value
    output logic pin_oe_n,                  // pin output enable, low drives
    output logic compare_output_pin,        // compare output register value
    output logic cmp_irq,                   // compare interrupt request
    output logic ovf_irq                    // overflow interrupt request
);
    // =====================================================
    // registers
    tmr_pkg::tmr_ctrl_a_t ctrl_a_reg;
    logic mode_hi_reg;
    logic [2:0] clk_sel_reg;
    logic [7:0] count_reg, count_next;
    logic [7:0] compare_value_reg;   // written by software
    logic [7:0] compare_active_reg;  // value used by comparator
    logic [1:0] mask_reg;
    logic cmp_flag_reg, ovf_flag_reg;
    logic dir_down_reg, dir_down_next;
    logic block_match_reg;
    logic oc_reg, oc_next;
    logic [9:0] presc_reg;

    // =====================================================
    // decode
    wire logic wr_a = bus.wr && bus.addr == tmr_pkg::ADDR_CTRL_A;
    wire logic wr_b = bus.wr && bus.addr == tmr_pkg::ADDR_CTRL_B;
    wire logic wr_cnt = bus.wr && bus.addr == tmr_pkg::ADDR_COUNT;
    wire logic wr_cmp = bus.wr && bus.addr == tmr_pkg::ADDR_COMPARE;
    wire logic wr_mask = bus.wr && bus.addr == tmr_pkg::ADDR_MASK;
    wire logic wr_flag = bus.wr && bus.addr == tmr_pkg::ADDR_FLAGS;
    wire tmr_pkg::tmr_ctrl_b_t wb = bus.wdata;

    tmr_pkg::tmr_mode_t mode;
    assign mode = tmr_pkg::tmr_mode_t'({mode_hi_reg, ctrl_a_reg.mode_lo});
    wire logic is_pc = mode == tmr_pkg::MODE_PC_FF || mode == tmr_pkg::MODE_PC_OCR;
    wire logic is_fast = mode == tmr_pkg::MODE_FAST_FF || mode == tmr_pkg::MODE_FAST_OCR;
    wire logic is_pwm = is_pc || is_fast;
    wire logic top_ocr = mode == tmr_pkg::MODE_CTC || mode == tmr_pkg::MODE_PC_OCR
        || mode == tmr_pkg::MODE_FAST_OCR;
    wire logic [7:0] top_val = top_ocr ? compare_active_reg : tmr_pkg::CNT_MAX;
    wire logic [1:0] act = ctrl_a_reg.action;

    function automatic logic tap_hit(input logic [2:0] cs, input logic [9:0] p);
        unique case (cs)
            tmr_pkg::CS_DIV1: tap_hit = 1'b1;
            tmr_pkg::CS_DIV8: tap_hit = p[2:0] == tmr_pkg::DIV8_LAST[2:0];
            tmr_pkg::CS_DIV64: tap_hit = p[5:0] == tmr_pkg::DIV64_LAST[5:0];
            tmr_pkg::CS_DIV256: tap_hit = p[7:0] == tmr_pkg::DIV256_LAST[7:0];
            tmr_pkg::CS_DIV1024: tap_hit = p == tmr_pkg::DIV1024_LAST;
            default: tap_hit = 1'b0;
        endcase
    endfunction
    wire logic tick = tap_hit(clk_sel_reg, presc_reg);

    // comparator, blocked one timer clock after a count write
    wire logic raw_match = count_reg == compare_active_reg;
    wire logic match = tick && raw_match && !block_match_reg;
    wire logic at_top = count_reg == top_val;
    // in pwm modes, waveform match ignored when compare equals top and upper action bit set
    wire logic skip_wave = is_pwm && act[1] && compare_active_reg == top_val;
    wire logic wave_match = match && !skip_wave;
    wire logic force_cmp = wr_b && wb.force_cmp && !is_pwm;

    // =====================================================
    // counter sequence
    always_comb begin
        count_next = count_reg;
        dir_down_next = dir_down_reg;
        if (tick) begin
            if (is_pc) begin
                // up to top, hold one tick, down to bottom
                if (!dir_down_reg && at_top) begin
                    dir_down_next = 1'b1;
                end else if (dir_down_reg && count_reg == tmr_pkg::CNT_BOTTOM) begin
                    dir_down_next = 1'b0;
                    count_next = count_reg + 8'h01;
                end else if (dir_down_reg) begin
                    count_next = count_reg - 8'h01;
                end else begin
                    count_next = count_reg + 8'h01;
                end
            // clear after top in fast pwm and ctc
            end else if ((is_fast || mode == tmr_pkg::MODE_CTC) && at_top) begin
                count_next = tmr_pkg::CNT_BOTTOM;
            end else begin
                count_next = count_reg + 8'h01;
            end
        end
        if (wr_cnt) begin
            count_next = bus.wdata;
        end
    end

    logic ovf_event;
    always_comb begin
        unique case (mode)
            tmr_pkg::MODE_PC_FF, tmr_pkg::MODE_PC_OCR:
                ovf_event = tick && dir_down_reg && count_reg == tmr_pkg::CNT_BOTTOM;
            tmr_pkg::MODE_FAST_OCR: ovf_event = tick && at_top;
            tmr_pkg::MODE_RES4, tmr_pkg::MODE_RES6: ovf_event = 1'b0;
            default: ovf_event = tick && count_reg == tmr_pkg::CNT_MAX;
        endcase
    end

    // =====================================================
    // waveform output
    always_comb begin
        oc_next = oc_reg;
        if (!is_pwm) begin
            if (wave_match || force_cmp) begin
                unique case (act)
                    tmr_pkg::ACT_TOGGLE: oc_next = !oc_reg;
                    tmr_pkg::ACT_CLEAR: oc_next = 1'b0;
                    tmr_pkg::ACT_SET: oc_next = 1'b1;
                    default: oc_next = oc_reg;
                endcase
            end
        end else if (act == tmr_pkg::ACT_TOGGLE) begin
            // toggle only with mode bit 2
            if (wave_match && mode_hi_reg) begin
                oc_next = !oc_reg;
            end
        end else if (act[1]) begin
            if (is_fast) begin
                // match then bottom action on clearing tick
                if (tick && at_top) begin
                    oc_next = act == tmr_pkg::ACT_CLEAR;
                end else if (wave_match) begin
                    oc_next = act == tmr_pkg::ACT_SET;
                end
            end else begin
                // at top instead of match; level matches a down-count match
                if (skip_wave && tick && at_top && !dir_down_reg) begin
                    oc_next = act == tmr_pkg::ACT_CLEAR;
                end else if (wave_match) begin
                    // up clears for 2, down sets for 2
                    oc_next = dir_down_reg ? (act == tmr_pkg::ACT_CLEAR) : (act == tmr_pkg::ACT_SET);
                end
            end
        end
    end

    // =====================================================
    // control and data registers
    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            ctrl_a_reg <= tmr_pkg::RESET_VALUE;
            mode_hi_reg <= 1'b0;
            clk_sel_reg <= tmr_pkg::CS_STOP;
            compare_value_reg <= tmr_pkg::RESET_VALUE;
            mask_reg <= 2'h0;
            presc_reg <= 10'h000;
        end else begin
            if (wr_a) begin
                ctrl_a_reg <= {bus.wdata[7:6], 4'h0, bus.wdata[1:0]};
            end
            if (wr_b) begin
                mode_hi_reg <= wb.mode_hi;
                clk_sel_reg <= wb.clk_sel;
            end
            if (wr_cmp) begin
                compare_value_reg <= bus.wdata;
            end
            if (wr_mask) begin
                mask_reg <= bus.wdata[1:0];
            end
            presc_reg <= presc_reg + 10'h001;
        end
    end

    // compare buffer: immediate outside pwm, at top in pwm
    wire logic load_cmp = !is_pwm || (tick && at_top);
    // counter, direction, match blocking and output
    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            count_reg <= tmr_pkg::CNT_BOTTOM;
            dir_down_reg <= 1'b0;
            block_match_reg <= 1'b0;
            oc_reg <= 1'b0;
            compare_active_reg <= tmr_pkg::RESET_VALUE;
        end else begin
            count_reg <= count_next;
            dir_down_reg <= dir_down_next;
            // held until the next timer clock passes
            block_match_reg <= wr_cnt || (block_match_reg && !tick);
            oc_reg <= oc_next;
            if (load_cmp) begin
                compare_active_reg <= wr_cmp && !is_pwm ? bus.wdata : compare_value_reg;
            end
        end
    end

    // flags: set wins over clear; forced compare sets none
    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            cmp_flag_reg <= 1'b0;
            ovf_flag_reg <= 1'b0;
        end else begin
            cmp_flag_reg <= match || (cmp_flag_reg && !cmp_irq_ack
                && !(wr_flag && bus.wdata[tmr_pkg::BIT_CMP]));
            ovf_flag_reg <= ovf_event || (ovf_flag_reg && !ovf_irq_ack
                && !(wr_flag && bus.wdata[tmr_pkg::BIT_OVF]));
        end
    end

    // read mux, unused bits zero, strobe reads zero
    logic [7:0] rd_mux;
    always_comb begin
        unique case (bus.addr)
            tmr_pkg::ADDR_CTRL_A: rd_mux = ctrl_a_reg;
            tmr_pkg::ADDR_CTRL_B: rd_mux = {4'h0, mode_hi_reg, clk_sel_reg};
            tmr_pkg::ADDR_COUNT: rd_mux = count_reg;
            tmr_pkg::ADDR_COMPARE: rd_mux = compare_value_reg;
            tmr_pkg::ADDR_MASK: rd_mux = {6'h00, mask_reg};
            tmr_pkg::ADDR_FLAGS: rd_mux = {6'h00, cmp_flag_reg, ovf_flag_reg};
            default: rd_mux = 8'h00;
        endcase
    end
    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            rdata <= tmr_pkg::RESET_VALUE;
        end else begin
            rdata <= bus.rd ? rd_mux : 8'h00;
        end
    end

    assign cmp_irq = cmp_flag_reg && mask_reg[tmr_pkg::BIT_CMP] && global_irq_en;
    assign ovf_irq = ovf_flag_reg && mask_reg[tmr_pkg::BIT_OVF] && global_irq_en;
    assign compare_output_pin = oc_reg;
    assign pin_out = act != tmr_pkg::ACT_OFF ? oc_reg : port_data;
    assign pin_oe_n = !port_dir_out;
endmodule
`default_nettype wire

// file: tmr_pkg.sv
// package for the 8-bit timer with one compare/pwm channel
// assumes a single i/o clock domain and a simple byte register port
package tmr_pkg;
    // =====================================================
    // register offsets
    localparam logic [7:0] ADDR_FLAGS = 8'h35;
    localparam logic [7:0] ADDR_CTRL_A = 8'h44;
    localparam logic [7:0] ADDR_CTRL_B = 8'h45;
    localparam logic [7:0] ADDR_COUNT = 8'h46;
    localparam logic [7:0] ADDR_COMPARE = 8'h47;
    localparam logic [7:0] ADDR_MASK = 8'h6e;
    localparam logic [7:0] RESET_VALUE = 8'h00;
    // =====================================================
    // counter landmarks
    localparam logic [7:0] CNT_MAX = 8'hff;
    localparam logic [7:0] CNT_BOTTOM = 8'h00;
    // =====================================================
    // prescaler taps (counts minus one)
    localparam logic [9:0] DIV8_LAST = 10'h007;
    localparam logic [9:0] DIV64_LAST = 10'h03f;
    localparam logic [9:0] DIV256_LAST = 10'h0ff;
    localparam logic [9:0] DIV1024_LAST = 10'h3ff;
    // =====================================================
    // waveform modes
    typedef enum logic [2:0] {
        MODE_NORMAL = 3'h0, MODE_PC_FF = 3'h1, MODE_CTC = 3'h2, MODE_FAST_FF = 3'h3,
        MODE_RES4 = 3'h4, MODE_PC_OCR = 3'h5, MODE_RES6 = 3'h6, MODE_FAST_OCR = 3'h7
    } tmr_mode_t;
    // output actions
    localparam logic [1:0] ACT_OFF = 2'h0;
    localparam logic [1:0] ACT_TOGGLE = 2'h1;
    localparam logic [1:0] ACT_CLEAR = 2'h2;
    localparam logic [1:0] ACT_SET = 2'h3;
    // clock select codes
    localparam logic [2:0] CS_STOP = 3'h0;
    localparam logic [2:0] CS_DIV1 = 3'h1;
    localparam logic [2:0] CS_DIV8 = 3'h2;
    localparam logic [2:0] CS_DIV64 = 3'h3;
    localparam logic [2:0] CS_DIV256 = 3'h4;
    localparam logic [2:0] CS_DIV1024 = 3'h5;
    // =====================================================
    // control register a and b fields
    typedef struct packed {
        logic [1:0] action;  // bits 7..6
        logic [3:0] unused;  // bits 5..2
        logic [1:0] mode_lo; // bits 1..0
    } tmr_ctrl_a_t;
    typedef struct packed {
        logic force_cmp;     // bit 7
        logic [2:0] unused;  // bits 6..4
        logic mode_hi;       // bit 3
        logic [2:0] clk_sel; // bits 2..0
    } tmr_ctrl_b_t;
    // bit positions in mask and flag registers
    localparam int BIT_CMP = 1;
    localparam int BIT_OVF = 0;
    // register port bundle
    typedef struct packed {
        logic [7:0] addr;
        logic [7:0] wdata;
        logic wr;
        logic rd;
    } tmr_bus_req_t;
endpackage

// file: tmr_timer_asserts.sv
// checker for the 8-bit timer, watching only the top module's ports
// assumes tmr_pkg is compiled first; attached by the bind at the foot
`timescale 1ns/1ps
`default_nettype none
module tmr_timer_chk (
    input wire logic ref_clk,               // i/o clock
    input wire logic sys_rst,               // sync reset
    input wire tmr_pkg::tmr_bus_req_t bus,  // register port
    input wire logic [7:0] rdata,           // read data
    input wire logic global_irq_en,         // global enable
    input wire logic cmp_irq_ack,           // compare ack
    input wire logic ovf_irq_ack,           // overflow ack
    input wire logic port_data,             // port data
    input wire logic port_dir_out,          // direction
    input wire logic pin_out,               // pin value
    input wire logic pin_oe_n,              // pin enable, low drives
    input wire logic compare_output_pin,    // waveform output
    input wire logic cmp_irq,               // compare request
    input wire logic ovf_irq                // overflow request
);
    // ==========================================
    // shadow of the output action field
    logic [1:0] act_reg;
    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            act_reg <= 2'h0;
        end else if (bus.wr && bus.addr == tmr_pkg::ADDR_CTRL_A) begin
            act_reg <= bus.wdata[7:6];
        end
    end
    default clocking @(posedge ref_clk); endclocking
    default disable iff (sys_rst);
    // read strobe at one address
    sequence rd_at(a);
        bus.rd && bus.addr == a;
    endsequence
    // ==========================================
    // assertions
    AST_OE_DIR: assert property (pin_oe_n == !port_dir_out)
        else $error("pin enable does not follow direction");
    AST_PIN_PORT: assert property (act_reg == 2'h0 |-> pin_out == port_data)
        else $error("pin not port data with action off");
    AST_PIN_CMP: assert property (act_reg != 2'h0 |-> pin_out == compare_output_pin)
        else $error("pin not compare output with action on");
    AST_CMP_IRQ: assert property (cmp_irq |-> global_irq_en)
        else $error("compare request without global enable");
    AST_OVF_IRQ: assert property (ovf_irq |-> global_irq_en)
        else $error("overflow request without global enable");
    AST_FORCE_RD: assert property (rd_at(tmr_pkg::ADDR_CTRL_B) |=> rdata[7:4] == 4'h0)
        else $error("control b upper bits not zero");
    AST_CTLA_RD: assert property (rd_at(tmr_pkg::ADDR_CTRL_A) |=> rdata[5:2] == 4'h0)
        else $error("control a unused bits not zero");
    AST_MASK_RD: assert property (rd_at(tmr_pkg::ADDR_MASK) |=> rdata[7:2] == 6'h00)
        else $error("mask unused bits not zero");
    AST_FLAG_RD: assert property (rd_at(tmr_pkg::ADDR_FLAGS) |=> rdata[7:2] == 6'h00)
        else $error("flag unused bits not zero");
    AST_RST_OUT: assert property ($past(sys_rst) |-> !compare_output_pin && !cmp_irq && !ovf_irq)
        else $error("outputs not cleared by reset");
endmodule
bind tmr_timer tmr_timer_chk tmr_timer_chk_i (.ref_clk(ref_clk), .sys_rst(sys_rst), .bus(bus), .rdata(rdata),
    .global_irq_en(global_irq_en), .cmp_irq_ack(cmp_irq_ack), .ovf_irq_ack(ovf_irq_ack), .port_data(port_data),
    .port_dir_out(port_dir_out), .pin_out(pin_out), .pin_oe_n(pin_oe_n), .compare_output_pin(compare_output_pin),
    .cmp_irq(cmp_irq), .ovf_irq(ovf_irq));
`default_nettype wire

// file: tb_tmr_timer.sv
// self-checking bench for the 8-bit timer
// assumes tmr_pkg, tmr_timer and the checker are compiled first
`timescale 1ns/1ps
`default_nettype none
module tb_tmr_timer;
    localparam logic [7:0] A_FL = tmr_pkg::ADDR_FLAGS;
    localparam logic [7:0] A_CA = tmr_pkg::ADDR_CTRL_A;
    localparam logic [7:0] A_CB = tmr_pkg::ADDR_CTRL_B;
    localparam logic [7:0] A_CN = tmr_pkg::ADDR_COUNT;
    localparam logic [7:0] A_CP = tmr_pkg::ADDR_COMPARE;
    localparam logic [7:0] A_MK = tmr_pkg::ADDR_MASK;
    logic ref_clk = 1'b0;
    logic sys_rst = 1'b1;
    tmr_pkg::tmr_bus_req_t bus = '0;
    logic global_irq_en = 1'b0, cmp_irq_ack = 1'b0, ovf_irq_ack = 1'b0, port_data = 1'b1, port_dir_out = 1'b1;
    logic [7:0] rdata, rv;
    logic pin_out, pin_oe_n, compare_output_pin, cmp_irq, ovf_irq;
    int mismatches = 0, samples_checked = 0, cycles = 0;
    tmr_timer tmr_timer_i (.ref_clk(ref_clk), .sys_rst(sys_rst), .bus(bus), .rdata(rdata),
        .global_irq_en(global_irq_en), .cmp_irq_ack(cmp_irq_ack), .ovf_irq_ack(ovf_irq_ack),
        .port_data(port_data), .port_dir_out(port_dir_out), .pin_out(pin_out), .pin_oe_n(pin_oe_n),
        .compare_output_pin(compare_output_pin), .cmp_irq(cmp_irq), .ovf_irq(ovf_irq));
    // ==========================================
    // clock, 40 ns period
    initial begin
        forever #20 ref_clk = ~ref_clk;
    end
    // hang guard
    always @(posedge ref_clk) begin
        cycles++;
        if (cycles == 40000) begin
            mismatches++;
            test_done();
        end
    end
    // ==========================================
    // bus and compare tasks
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge ref_clk);
        bus <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
        @(posedge ref_clk);
        bus.wr <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(posedge ref_clk);
        bus <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
        @(posedge ref_clk);
        bus.rd <= 1'b0;
        #1 d = rdata;
    endtask
    task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
        samples_checked++;
        if (g !== e) begin
            mismatches++;
            $display("BAD %s expected %h seen %h", n, e, g);
        end
    endtask
    task automatic chk_rng(input string n, input logic [15:0] lo, input logic [15:0] hi, input logic [15:0] g);
        samples_checked++;
        if ((g >= lo && g <= hi) !== 1'b1) begin
            mismatches++;
            $display("BAD %s expected %0d..%0d seen %0d", n, lo, hi, g);
        end
    endtask
    // counts cycles with the waveform output high
    task automatic count_hi(input int n, output logic [15:0] h);
        h = 16'h0000;
        repeat (n) begin
            @(posedge ref_clk);
            #1 if (compare_output_pin === 1'b1) h++;
        end
    endtask
    // ==========================================
    // scenarios
    task automatic t_regs;
        logic [7:0] ad[7] = '{A_FL, A_CA, A_CB, A_CN, A_CP, A_MK, 8'h50};
        foreach (ad[i]) begin
            rd(ad[i], rv);
            chk("reset value", 8'h00, rv);
        end
        wr(A_CA, 8'hff);
        rd(A_CA, rv);
        chk("ctrl a", 8'hc3, rv);
        // force strobe written as zero while a pwm mode is set
        wr(A_CB, 8'h38);
        rd(A_CB, rv);
        chk("ctrl b", 8'h08, rv);
        wr(A_MK, 8'hff);
        rd(A_MK, rv);
        chk("mask", 8'h03, rv);
        wr(8'h50, 8'hff);
        rd(8'h50, rv);
        chk("unmapped", 8'h00, rv);
        wr(A_CA, 8'h00);
        wr(A_CB, 8'h00);
        $display("test regs done");
    endtask
    task automatic t_normal;
        wr(A_CN, 8'hfd);
        wr(A_CB, tmr_pkg::CS_DIV1);
        repeat (10) @(posedge ref_clk);
        wr(A_CB, 8'h00);
        rd(A_FL, rv);
        chk("flags after wrap", 8'h03, rv);
        @(posedge ref_clk);
        global_irq_en <= 1'b1;
        @(posedge ref_clk);
        #1 chk("irqs", 8'h03, {6'h00, cmp_irq, ovf_irq});
        @(posedge ref_clk);
        global_irq_en <= 1'b0;
        @(posedge ref_clk);
        #1 chk("irqs masked", 8'h00, {6'h00, cmp_irq, ovf_irq});
        @(posedge ref_clk);
        global_irq_en <= 1'b1;
        cmp_irq_ack <= 1'b1;
        @(posedge ref_clk);
        cmp_irq_ack <= 1'b0;
        rd(A_FL, rv);
        chk("flags after ack", 8'h01, rv);
        wr(A_FL, 8'h01);
        rd(A_FL, rv);
        chk("flags write one", 8'h00, rv);
        #1 chk("irqs cleared", 8'h00, {6'h00, cmp_irq, ovf_irq});
        $display("test normal done");
    endtask
    task automatic t_ctc;
        wr(A_CN, 8'h00);
        wr(A_CA, 8'h02);
        wr(A_CP, 8'h05);
        wr(A_CB, tmr_pkg::CS_DIV1);
        repeat (37) @(posedge ref_clk);
        wr(A_CB, 8'h00);
        rd(A_CN, rv);
        chk_rng("ctc count", 0, 5, {8'h00, rv});
        rd(A_FL, rv);
        chk("ctc flags", 8'h02, rv);
        wr(A_FL, 8'h03);
        $display("test ctc done");
    endtask
    task automatic t_force;
        logic [7:0] act[4] = '{8'hc0, 8'h80, 8'h40, 8'h40};
        logic [7:0] e[4] = '{8'h01, 8'h00, 8'h01, 8'h00};
        foreach (act[i]) begin
            wr(A_CA, act[i]);
            wr(A_CB, 8'h80);
            #1 chk("forced output", e[i], {7'h00, compare_output_pin});
        end
        rd(A_FL, rv);
        chk("forced flags", 8'h00, rv);
        rd(A_CB, rv);
        chk("force readback", 8'h00, rv);
        wr(A_CA, 8'h02);
        wr(A_CN, 8'h03);
        wr(A_CB, 8'h80);
        rd(A_CN, rv);
        chk("ctc force count", 8'h03, rv);
        $display("test force done");
    endtask
    task automatic t_pwm;
        logic [7:0] ca[3] = '{8'h83, 8'hc3, 8'h81};
        int lo[3] = '{250, 248, 248};
        int hi[3] = '{264, 262, 264};
        int n[3] = '{512, 512, 1020};
        logic [15:0] h;
        wr(A_CP, 8'h80);
        wr(A_CB, tmr_pkg::CS_DIV1);
        foreach (ca[i]) begin
            if (i == 2) wr(A_CP, 8'h40);
            wr(A_CA, ca[i]);
            repeat (1100) @(posedge ref_clk);
            count_hi(n[i], h);
            chk_rng("pwm high cycles", lo[i], hi[i], h);
        end
        wr(A_CB, 8'h00);
        wr(A_CA, 8'h00);
        wr(A_FL, 8'h03);
        $display("test pwm done");
    endtask
    task automatic t_presc;
        int dv[4] = '{8, 64, 256, 1024};
        foreach (dv[i]) begin
            wr(A_CN, 8'h00);
            wr(A_CB, 8'(i + 2));
            repeat (dv[i] * 10) @(posedge ref_clk);
            wr(A_CB, 8'h00);
            rd(A_CN, rv);
            chk_rng("prescaled count", 9, 12, {8'h00, rv});
        end
        $display("test prescaler done");
    endtask
    // closing report
    task automatic test_done;
        $display("checked %0d mismatches %0d", samples_checked, mismatches);
        if (mismatches == 0 && samples_checked > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask
    // main sequence
    initial begin
        repeat (10) @(posedge ref_clk);
        sys_rst <= 1'b0;
        t_regs();
        t_normal();
        t_ctc();
        t_force();
        t_pwm();
        t_presc();
        test_done();
    end
endmodule
`default_nettype wire
